/* bench/adc_analog_model.sv */
`timescale 1ns/10ps
module adc_analog_model (
	input wire logic mclk,
	input wire logic sar_sample_start,
	input wire logic conversion_busy_out,
	input wire logic [11:0] next_raw,
	output adc_ctrl_pkg::sample_t sar_sample
);
	logic [11:0] held;
	logic active;
	logic busy_q;
	initial begin
		held = 12'h5a5;
		active = 1'b0;
		busy_q = 1'b0;
	end
	// outside a conversion the line toggles, so a stale sample never reads as valid data
	always @(posedge mclk) begin
		busy_q <= conversion_busy_out;
		if (sar_sample_start) begin
			held <= next_raw;
			active <= 1'b1;
		end else if (busy_q && !conversion_busy_out) begin
			active <= 1'b0;
		end else if (!active) begin
			held <= ~held;
		end
	end
	assign sar_sample.raw = held;
	assign sar_sample.valid = active;
endmodule

/* bench/sar_adc_sequencing_and_status_test.sv */
`timescale 1ns/10ps
module sar_adc_sequencing_and_status_test;
	logic mclk, reset, psel, penable, pwrite, pready, pslverr, sar_sample_start, adc_irq;
	logic bypass_pos_buffer, bypass_neg_buffer, amp_in_path, adc_power;
	logic conversion_busy_out, gpio_busy_pin, gexp;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_data, x, v32;
	logic [4:0] trg, positive_channel_select, front_amp_a, front_amp_b;
	logic [3:0] negative_channel_select;
	logic [11:0] gain_cal, offset_cal, next_raw, v;
	adc_ctrl_pkg::sample_t sar_sample;
	logic [31:0] rd_q[$];
	int dur_q[$];
	int n_mismatch, tests_run, busy_n;
	int codes[5] = '{0, 1, 2, 5, 6};
	event rd_ev;
	adc_ctrl i_adc_ctrl (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_convert_trigger(trg[0]), .timer1_trigger(trg[1]),
		.timer0_trigger(trg[2]), .logic_array_trigger(trg[3]), .pwm_trigger(trg[4]),
		.sar_sample(sar_sample), .sar_sample_start(sar_sample_start),
		.positive_channel_select(positive_channel_select),
		.negative_channel_select(negative_channel_select),
		.bypass_pos_buffer(bypass_pos_buffer), .bypass_neg_buffer(bypass_neg_buffer),
		.amp_in_path(amp_in_path), .front_amp_a(front_amp_a), .front_amp_b(front_amp_b),
		.gain_cal(gain_cal), .offset_cal(offset_cal), .adc_power(adc_power),
		.adc_irq(adc_irq), .conversion_busy_out(conversion_busy_out),
		.gpio_busy_pin(gpio_busy_pin));
	adc_analog_model i_adc_analog_model (.mclk(mclk), .sar_sample_start(sar_sample_start),
		.conversion_busy_out(conversion_busy_out), .next_raw(next_raw),
		.sar_sample(sar_sample));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	function automatic logic [31:0] xs();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic err(input string m);
		n_mismatch++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err($sformatf("%s got %h want %h", m, got, exp));
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err("no ready");
			wrap_up();
		end
		rd_data = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		apb(1'b0, a, 32'h0);
		-> rd_ev;
	endtask
	// watchers: read data and measured busy length against the oldest note
	initial forever begin
		@(rd_ev);
		chk(rd_data, rd_q.pop_front(), "read data");
	end
	always @(negedge mclk) begin
		if (conversion_busy_out === 1'b1) begin
			busy_n++;
		end else if (busy_n > 0) begin
			chk(busy_n, dur_q.pop_front(), "busy length");
			busy_n = 0;
		end
	end
	task automatic conv(input logic [31:0] c, input logic [4:0] t, input int dur);
		int n;
		dur_q.push_back(dur);
		apb(1'b1, adc_ctrl_pkg::ctrl_off, c);
		trg <= t;
		n = 0;
		while (conversion_busy_out !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 300) begin
			err("no start");
			wrap_up();
		end
		chk(gpio_busy_pin, gexp, "gpio busy");
		@(posedge mclk);
		trg <= 5'h0;
		n = 0;
		while (conversion_busy_out !== 1'b0 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000) begin
			err("conversion hang");
			wrap_up();
		end
		@(negedge mclk);
	endtask
	initial begin
		x = 32'h0000_0059;
		{reset, psel, penable, pwrite, gexp} = 5'b10000;
		{paddr, pwdata, trg, next_raw} = '0;
		n_mismatch = 0;
		tests_run = 0;
		busy_n = 0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		rd(adc_ctrl_pkg::ctrl_off, 32'h0000_0a00);
		rd(adc_ctrl_pkg::status_off, 32'h0);
		rd(8'h28, 32'h0);
		apb(1'b1, adc_ctrl_pkg::pos_sel_off, 32'h6);
		next_raw = 12'(xs());
		conv(32'h0aa3, 5'h0, 54);
		chk(adc_irq, 1'b1, "irq");
		rd(adc_ctrl_pkg::status_off, 32'h1);
		rd(adc_ctrl_pkg::result_off, {4'h0, next_raw, 16'h0});
		rd(adc_ctrl_pkg::result_off, {4'h0, next_raw, 16'h0});
		rd(adc_ctrl_pkg::status_off, 32'h0);
		rd(adc_ctrl_pkg::ctrl_off, 32'h0000_0aa0);
		// continuous mode: a second conversion must follow, then stop once the trigger is set back to the pin
		dur_q.push_back(54);
		conv(32'h0aa4, 5'h0, 54);
		apb(1'b1, adc_ctrl_pkg::ctrl_off, 32'h0aa0);
		repeat (60) @(posedge mclk);
		rd(adc_ctrl_pkg::status_off, 32'h1);
		for (int i = 0; i < 5; i++) begin
			next_raw = 12'(xs());
			v = (i == 4) ? next_raw : next_raw ^ 12'h800;
			v32 = {16'h0, 2'b00, 3'(i), 3'(i), 3'b101, (i == 4) ? 2'b10 : 2'b01, 3'(codes[i])};
			conv(v32, 5'h1 << i, ((2 << i) + 19) * (1 << i));
			rd(adc_ctrl_pkg::result_off, {{4{v[11] & (i != 4)}}, v, 16'h0});
		end
		apb(1'b1, adc_ctrl_pkg::gpio_cfg_off, 32'h1);
		gexp = 1'b1;
		apb(1'b1, adc_ctrl_pkg::pos_sel_off, 32'h10);
		conv(32'h0aa3, 5'h0, 1120);
		apb(1'b1, adc_ctrl_pkg::pos_sel_off, 32'h6);
		conv(32'h0aa3, 5'h0, 54);
		apb(1'b1, adc_ctrl_pkg::amp_gain_off, 32'h3e1);
		apb(1'b1, adc_ctrl_pkg::gain_cal_off, 32'habc);
		apb(1'b1, adc_ctrl_pkg::offset_cal_off, 32'h123);
		apb(1'b1, adc_ctrl_pkg::neg_sel_off, 32'h5);
		apb(1'b1, adc_ctrl_pkg::ctrl_off, 32'hc000);
		@(negedge mclk);
		chk({positive_channel_select, negative_channel_select, adc_power, pslverr}, 11'h194,
			"channel and power");
		chk({front_amp_b, front_amp_a}, 10'h3e1, "amp gains");
		chk({amp_in_path, gain_cal, offset_cal}, 25'h0abc123, "cal plain");
		chk({bypass_pos_buffer, bypass_neg_buffer}, 2'b11, "bypass");
		apb(1'b1, adc_ctrl_pkg::pos_sel_off, 32'h0);
		@(negedge mclk);
		chk({amp_in_path, gain_cal, offset_cal}, 25'h1000123, "cal amplified");
		apb(1'b1, adc_ctrl_pkg::block_reset_off, 32'h7);
		rd(adc_ctrl_pkg::ctrl_off, 32'h0000_0a00);
		rd(adc_ctrl_pkg::amp_gain_off, 32'h0);
		@(negedge mclk);
		chk({front_amp_a, offset_cal, bypass_pos_buffer}, 18'h0, "after block reset");
		repeat (3) @(posedge mclk);
		wrap_up();
	end
	initial begin
		#4000000;
		err("run timeout");
		wrap_up();
	end
endmodule

/* design/adc_ctrl.sv */
`timescale 1ns/10ps
module adc_ctrl (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_convert_trigger,
	input wire logic timer0_trigger,
	input wire logic timer1_trigger,
	input wire logic logic_array_trigger,
	input wire logic pwm_trigger,
	input wire adc_ctrl_pkg::sample_t sar_sample,
	output logic sar_sample_start,
	output logic [4:0] positive_channel_select,
	output logic [3:0] negative_channel_select,
	output logic bypass_pos_buffer,
	output logic bypass_neg_buffer,
	output logic amp_in_path,
	output logic [4:0] front_amp_a,
	output logic [4:0] front_amp_b,
	output logic [11:0] gain_cal,
	output logic [11:0] offset_cal,
	output logic adc_power,
	output logic adc_irq,
	output logic conversion_busy_out,
	output logic gpio_busy_pin
);
	logic [15:0] converter_control_reg;
	logic [4:0] pos_sel_reg;
	logic [3:0] neg_sel_reg;
	logic result_ready_flag;
	logic [31:0] conversion_result_reg;
	logic [11:0] gain_calibration_reg;
	logic [11:0] offset_calibration_reg;
	logic [9:0] amplifier_gain_reg;
	logic gpio_output_config;
	adc_ctrl_pkg::conv_state_t state_reg;
	logic [4:0] prescale_reg;
	logic [7:0] clk_count_reg;
	logic [2:0] div_code_reg;
	logic [2:0] acq_code_reg;
	logic [1:0] mode_latched_reg;
	logic temp_conv_reg;
	logic wr_en, rd_en, soft_reset, tick, start, done, trig_level;
	logic [2:0] trigger_type;

	function automatic logic [4:0] div_limit(input logic [2:0] code);
		div_limit = (5'h01 << code) - 5'h01;
	endfunction

	function automatic logic [7:0] acq_clocks(input logic [2:0] code);
		acq_clocks = 8'h02 << code;
	endfunction

	function automatic logic [31:0] format_result(input logic [11:0] raw, input logic [1:0] mode);
		logic [11:0] val;
		val = raw;
		if (mode == adc_ctrl_pkg::mode_diff) begin
			val = raw ^ 12'h800;
		end
		format_result = {{4{val[11] & (mode == adc_ctrl_pkg::mode_diff)}}, val, 16'h0000};
	endfunction

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign soft_reset = wr_en && paddr == adc_ctrl_pkg::block_reset_off;
	assign trigger_type = converter_control_reg[2:0];

	always_comb begin
		case (trigger_type)
			adc_ctrl_pkg::trig_pin: trig_level = external_convert_trigger;
			adc_ctrl_pkg::trig_timer1: trig_level = timer1_trigger;
			adc_ctrl_pkg::trig_timer0: trig_level = timer0_trigger;
			adc_ctrl_pkg::trig_sw_single: trig_level = 1'b1;
			adc_ctrl_pkg::trig_sw_cont: trig_level = 1'b1;
			adc_ctrl_pkg::trig_logic: trig_level = logic_array_trigger;
			adc_ctrl_pkg::trig_pwm: trig_level = pwm_trigger;
			default: trig_level = 1'b0;
		endcase
	end

	assign start = state_reg == adc_ctrl_pkg::st_idle && trig_level
		&& converter_control_reg[adc_ctrl_pkg::ctrl_enable_bit]
		&& converter_control_reg[adc_ctrl_pkg::ctrl_power_bit];
	assign tick = prescale_reg == div_limit(div_code_reg);
	assign done = state_reg == adc_ctrl_pkg::st_convert && tick && clk_count_reg == 8'h01;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			converter_control_reg <= adc_ctrl_pkg::ctrl_reset;
			pos_sel_reg <= 5'h00;
			neg_sel_reg <= 4'h0;
			gain_calibration_reg <= 12'h000;
			offset_calibration_reg <= 12'h000;
			amplifier_gain_reg <= 10'h000;
			gpio_output_config <= 1'b0;
		end else if (soft_reset) begin
			converter_control_reg <= adc_ctrl_pkg::ctrl_reset;
			pos_sel_reg <= 5'h00;
			neg_sel_reg <= 4'h0;
			gain_calibration_reg <= 12'h000;
			offset_calibration_reg <= 12'h000;
			amplifier_gain_reg <= 10'h000;
			gpio_output_config <= 1'b0;
		end else if (wr_en) begin
			// revert even when another register is written; a control write wins
			if (done && trigger_type == adc_ctrl_pkg::trig_sw_single) begin
				converter_control_reg[2:0] <= adc_ctrl_pkg::trig_pin;
			end
			if (paddr == adc_ctrl_pkg::ctrl_off) begin
				converter_control_reg <= pwdata[15:0] & 16'hffbf;
			end else if (paddr == adc_ctrl_pkg::pos_sel_off) begin
				pos_sel_reg <= pwdata[4:0];
			end else if (paddr == adc_ctrl_pkg::neg_sel_off) begin
				neg_sel_reg <= pwdata[3:0];
			end else if (paddr == adc_ctrl_pkg::gain_cal_off) begin
				gain_calibration_reg <= pwdata[11:0];
			end else if (paddr == adc_ctrl_pkg::offset_cal_off) begin
				offset_calibration_reg <= pwdata[11:0];
			end else if (paddr == adc_ctrl_pkg::amp_gain_off) begin
				amplifier_gain_reg <= pwdata[9:0];
			end else if (paddr == adc_ctrl_pkg::gpio_cfg_off) begin
				gpio_output_config <= pwdata[0];
			end
		end else if (done && trigger_type == adc_ctrl_pkg::trig_sw_single) begin
			converter_control_reg[2:0] <= adc_ctrl_pkg::trig_pin;
		end
	end

	// timing captured at start so a mid-conversion write cannot disturb it
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= adc_ctrl_pkg::st_idle;
			prescale_reg <= 5'h00;
			clk_count_reg <= 8'h00;
			div_code_reg <= 3'h1;
			acq_code_reg <= 3'h2;
			mode_latched_reg <= adc_ctrl_pkg::mode_single;
			temp_conv_reg <= 1'b0;
		end else if (soft_reset) begin
			state_reg <= adc_ctrl_pkg::st_idle;
			prescale_reg <= 5'h00;
			clk_count_reg <= 8'h00;
		end else begin
			prescale_reg <= (state_reg == adc_ctrl_pkg::st_idle || tick) ? 5'h00 : prescale_reg + 5'h01;
			case (state_reg)
				adc_ctrl_pkg::st_idle: begin
					if (start) begin
						state_reg <= adc_ctrl_pkg::st_acquire;
						mode_latched_reg <= converter_control_reg[4:3];
						temp_conv_reg <= pos_sel_reg == adc_ctrl_pkg::temp_channel;
						if (pos_sel_reg == adc_ctrl_pkg::temp_channel) begin
							div_code_reg <= adc_ctrl_pkg::temp_div_code;
							acq_code_reg <= adc_ctrl_pkg::temp_acq_code;
							clk_count_reg <= acq_clocks(adc_ctrl_pkg::temp_acq_code);
						end else begin
							div_code_reg <= converter_control_reg[13:11];
							acq_code_reg <= converter_control_reg[10:8];
							clk_count_reg <= acq_clocks(converter_control_reg[10:8]);
						end
					end
				end
				adc_ctrl_pkg::st_acquire: begin
					if (tick) begin
						if (clk_count_reg == 8'h01) begin
							state_reg <= adc_ctrl_pkg::st_convert;
							clk_count_reg <= adc_ctrl_pkg::trial_clocks;
						end else begin
							clk_count_reg <= clk_count_reg - 8'h01;
						end
					end
				end
				adc_ctrl_pkg::st_convert: begin
					if (tick) begin
						if (clk_count_reg == 8'h01) begin
							state_reg <= adc_ctrl_pkg::st_idle;
						end else begin
							clk_count_reg <= clk_count_reg - 8'h01;
						end
					end
				end
				default: state_reg <= adc_ctrl_pkg::st_idle;
			endcase
		end
	end

	// set wins over a read clear in the same cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			result_ready_flag <= 1'b0;
			conversion_result_reg <= 32'h0000_0000;
		end else if (soft_reset) begin
			result_ready_flag <= 1'b0;
			conversion_result_reg <= 32'h0000_0000;
		end else if (done) begin
			result_ready_flag <= 1'b1;
			conversion_result_reg <= format_result(sar_sample.raw, mode_latched_reg);
		end else if (rd_en && paddr == adc_ctrl_pkg::result_off) begin
			result_ready_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == adc_ctrl_pkg::ctrl_off) begin
				prdata <= {16'h0000, converter_control_reg};
			end else if (paddr == adc_ctrl_pkg::pos_sel_off) begin
				prdata <= {27'h0000000, pos_sel_reg};
			end else if (paddr == adc_ctrl_pkg::neg_sel_off) begin
				prdata <= {28'h0000000, neg_sel_reg};
			end else if (paddr == adc_ctrl_pkg::status_off) begin
				prdata <= {31'h00000000, result_ready_flag};
			end else if (paddr == adc_ctrl_pkg::result_off) begin
				prdata <= conversion_result_reg;
			end else if (paddr == adc_ctrl_pkg::gain_cal_off) begin
				prdata <= {20'h00000, gain_calibration_reg};
			end else if (paddr == adc_ctrl_pkg::offset_cal_off) begin
				prdata <= {20'h00000, offset_calibration_reg};
			end else if (paddr == adc_ctrl_pkg::amp_gain_off) begin
				prdata <= {22'h000000, amplifier_gain_reg};
			end else if (paddr == adc_ctrl_pkg::gpio_cfg_off) begin
				prdata <= {31'h00000000, gpio_output_config};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	always_comb begin
		amp_in_path = pos_sel_reg == adc_ctrl_pkg::amp_chan_a
			|| pos_sel_reg == adc_ctrl_pkg::amp_chan_b;
		gain_cal = amp_in_path ? 12'h000 : gain_calibration_reg;
	end

	assign offset_cal = offset_calibration_reg;
	assign bypass_pos_buffer = converter_control_reg[adc_ctrl_pkg::ctrl_bypass_pos_bit];
	assign bypass_neg_buffer = converter_control_reg[adc_ctrl_pkg::ctrl_bypass_neg_bit];
	assign front_amp_a = amplifier_gain_reg[4:0];
	assign front_amp_b = amplifier_gain_reg[9:5];
	assign positive_channel_select = pos_sel_reg;
	assign negative_channel_select = neg_sel_reg;
	assign adc_power = converter_control_reg[adc_ctrl_pkg::ctrl_power_bit];
	assign adc_irq = result_ready_flag;
	assign conversion_busy_out = state_reg != adc_ctrl_pkg::st_idle;
	assign gpio_busy_pin = conversion_busy_out && gpio_output_config;
	assign sar_sample_start = start;

	ready_on_done_a: assert property (@(posedge mclk) disable iff (reset)
		done && !soft_reset |=> result_ready_flag) else $error("ready not set");
	read_clears_a: assert property (@(posedge mclk) disable iff (reset)
		rd_en && paddr == adc_ctrl_pkg::result_off && !done && !soft_reset
		|=> !result_ready_flag) else $error("ready not cleared");
	busy_level_a: assert property (@(posedge mclk) disable iff (reset)
		start && !soft_reset |=> conversion_busy_out) else $error("busy missing");
	busy_gate_a: assert property (@(posedge mclk) disable iff (reset)
		!gpio_output_config |-> !gpio_busy_pin) else $error("busy leaked");
	temp_force_a: assert property (@(posedge mclk) disable iff (reset)
		start && pos_sel_reg == adc_ctrl_pkg::temp_channel && !soft_reset
		|=> div_code_reg == adc_ctrl_pkg::temp_div_code
		&& acq_code_reg == adc_ctrl_pkg::temp_acq_code
		&& clk_count_reg == 8'h10) else $error("temp timing");
	user_timing_a: assert property (@(posedge mclk) disable iff (reset)
		start && pos_sel_reg != adc_ctrl_pkg::temp_channel && !soft_reset
		|=> div_code_reg == $past(converter_control_reg[13:11])
		&& acq_code_reg == $past(converter_control_reg[10:8])) else $error("user timing");
	result_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!done && !soft_reset |=> $stable(conversion_result_reg)) else $error("result moved");
	soft_reset_a: assert property (@(posedge mclk) disable iff (reset)
		soft_reset |=> converter_control_reg == adc_ctrl_pkg::ctrl_reset) else $error("no reset");
	single_revert_a: assert property (@(posedge mclk) disable iff (reset)
		done && trigger_type == adc_ctrl_pkg::trig_sw_single
		&& !(wr_en && paddr == adc_ctrl_pkg::ctrl_off)
		|=> trigger_type == adc_ctrl_pkg::trig_pin) else $error("no revert");
	// checked only when a result lands, since the mode may change before the next read
	sign_ext_a: assert property (@(posedge mclk) disable iff (reset)
		done && !soft_reset |=> conversion_result_reg[31:28]
		== ((mode_latched_reg == adc_ctrl_pkg::mode_diff) ? {4{conversion_result_reg[27]}} : 4'h0))
		else $error("sign bits");
	conv_done_c: cover property (@(posedge mclk) disable iff (reset) done);
	temp_conv_c: cover property (@(posedge mclk) disable iff (reset) done && temp_conv_reg);
	read_clear_c: cover property (@(posedge mclk) disable iff (reset)
		result_ready_flag ##1 !result_ready_flag);
	cont_restart_c: cover property (@(posedge mclk) disable iff (reset) done ##1 start);
endmodule

/* design/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] pos_sel_off = 8'h04;
	localparam logic [7:0] neg_sel_off = 8'h08;
	localparam logic [7:0] status_off = 8'h0c;
	localparam logic [7:0] result_off = 8'h10;
	localparam logic [7:0] block_reset_off = 8'h14;
	localparam logic [7:0] gain_cal_off = 8'h18;
	localparam logic [7:0] offset_cal_off = 8'h1c;
	localparam logic [7:0] amp_gain_off = 8'h20;
	localparam logic [7:0] gpio_cfg_off = 8'h24;
	// control fields and reset values
	localparam logic [15:0] ctrl_reset = 16'h0a00;
	localparam int ctrl_bypass_pos_bit = 15;
	localparam int ctrl_bypass_neg_bit = 14;
	localparam int ctrl_div_lsb = 11;
	localparam int ctrl_acq_lsb = 8;
	localparam int ctrl_enable_bit = 7;
	localparam int ctrl_power_bit = 5;
	localparam int ctrl_mode_lsb = 3;
	localparam logic [1:0] mode_single = 2'h0;
	localparam logic [1:0] mode_diff = 2'h1;
	localparam logic [1:0] mode_pseudo = 2'h2;
	localparam logic [2:0] trig_pin = 3'h0;
	localparam logic [2:0] trig_timer1 = 3'h1;
	localparam logic [2:0] trig_timer0 = 3'h2;
	localparam logic [2:0] trig_sw_single = 3'h3;
	localparam logic [2:0] trig_sw_cont = 3'h4;
	localparam logic [2:0] trig_logic = 3'h5;
	localparam logic [2:0] trig_pwm = 3'h6;
	localparam logic [4:0] temp_channel = 5'h10;
	localparam logic [4:0] amp_chan_a = 5'h00;
	localparam logic [4:0] amp_chan_b = 5'h01;
	localparam logic [2:0] temp_div_code = 3'h5;
	localparam logic [2:0] temp_acq_code = 3'h3;
	localparam logic [7:0] trial_clocks = 8'h13;
	localparam int result_lsb = 16;
	localparam logic [31:0] block_reset_key = 32'h0000_0007;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_acquire = 3'b010,
		st_convert = 3'b100
	} conv_state_t;
	typedef struct packed {
		logic [11:0] raw;
		logic valid;
	} sample_t;
endpackage
